// ==== core/usbmc_regs.sv ====
// module: main control register group of the usb node, avalon-mm slave
`timescale 1ns/1ps
module usbmc_regs
  import usbmc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h5     // arbitrary neutral revision value
)
(
  input  wire logic        clock,            // system clock, 50 mhz
  input  wire logic        rst,              // hardware reset, async high
  input  wire logic [3:0]  address,          // avalon byte address
  input  wire logic        read,             // avalon read request
  input  wire logic        write,            // avalon write request
  input  wire logic [31:0] writedata,        // avalon write data
  input  wire logic [3:0]  byteenable,       // avalon byte enables
  output logic [31:0]      readdata,         // avalon read data, registered
  output logic             waitrequest,      // avalon stall
  input  wire logic        irq_request,      // device interrupt, same clock
  output logic             irq_pin_o,        // interrupt pin level
  output logic             irq_pin_oe,       // interrupt pin drive enable
  output logic             clock_output_pin, // divided clock output
  input  wire logic        bus_activity,     // usb non-idle from transceiver pin
  output logic             resume_detect,    // one-cycle resume event pulse
  output logic             soft_reset_out,   // device-wide soft reset level
  output usbmc_node_ctl_t  node_ctl          // transceiver and endpoint controls
);

  // bus handshake and read path
  logic        ack_r;          // answer cycle of the current request
  logic        ack_nxt;
  logic [31:0] rdata_r;        // registered read data
  logic [31:0] rdata_nxt;
  logic        wr_commit;      // write takes effect at this edge

  // register storage
  usbmc_main_t       main_r;   // main control fields
  usbmc_main_t       main_nxt;
  usbmc_clkcfg_t     ccfg_r;   // clock configuration
  usbmc_clkcfg_t     ccfg_nxt;
  usbmc_node_state_t node_r;   // node functional state
  usbmc_node_state_t node_nxt;
  logic [3:0]        soft_reset_bit_cnt_r;  // cycles left in soft reset
  logic [3:0]        soft_reset_bit_cnt_nxt;
  logic              soft_reset_bit_act;    // soft reset sequence running

  // pin and output registers
  logic            irq_o_r;    // interrupt pin level
  logic            irq_o_nxt;
  logic            irq_oe_r;   // interrupt pin enable
  logic            irq_oe_nxt;
  usbmc_node_ctl_t ctl_r;      // registered node controls
  usbmc_node_ctl_t ctl_nxt;

  // bus activity synchroniser and edge detector
  logic act_s1_r;   // first stage, read only by second
  logic act_s2_r;   // second stage
  logic act_s3_r;   // delayed copy for edge detect
  logic rsm_r;      // resume event pulse
  logic rsm_nxt;

  // true when a committed write targets the given offset with lane 0 enabled
  function automatic logic wr_hit(input logic [3:0] ofs);
    wr_hit = wr_commit && (address == ofs) && byteenable[0];
  endfunction

  // one wait cycle per request, then a single answer cycle
  always_comb begin
    ack_nxt   = (read || write) && !ack_r;
    wr_commit = write && ack_r;
  end

  assign waitrequest = (read || write) && !ack_r;

  // read mux, reserved bits read as zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (read && !ack_r) begin
      rdata_nxt = 32'h0000_0000;
      case (address)
        MAIN_CONTROL_OFS: begin
          rdata_nxt[SOFT_RESET_BIT_POS]   = soft_reset_bit_act;
          rdata_nxt[REGULATOR_ENABLE_POS] = main_r.regulator_enable;
          rdata_nxt[ATTACH_BIT_POS]       = main_r.attach_bit;
          rdata_nxt[IRQ_MODE_LSB +: 2]    = main_r.irq_output_mode;
        end
        CLOCK_CONFIGURATION_OFS: begin
          rdata_nxt[CLOCK_DIVISOR_LSB +: 4] = ccfg_r.clock_divisor;
          rdata_nxt[CLOCK_OUT_DIS_POS]      = ccfg_r.clock_output_disable;
        end
        CHIP_REVISION_OFS: begin
          rdata_nxt[3:0] = REVISION;
        end
        NODE_STATE_CONTROL_OFS: begin
          rdata_nxt[NODE_STATE_LSB +: 2] = node_r;
        end
        default: begin
          rdata_nxt = 32'h0000_0000;  // unmapped reads answer zero
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign readdata = rdata_r;

  // soft reset sequencer: a write of one starts a fixed-length count
  always_comb begin
    soft_reset_bit_act     = (soft_reset_bit_cnt_r != 4'h0);
    soft_reset_bit_cnt_nxt = soft_reset_bit_cnt_r;
    if (soft_reset_bit_act) begin
      soft_reset_bit_cnt_nxt = soft_reset_bit_cnt_r - 4'h1;
    end else if (wr_hit(MAIN_CONTROL_OFS) && writedata[SOFT_RESET_BIT_POS]) begin
      soft_reset_bit_cnt_nxt = SOFT_RESET_CYCLES;
    end
  end

  // main control and node state, soft reset wins over software writes
  always_comb begin
    main_nxt = main_r;
    node_nxt = node_r;
    if (wr_hit(MAIN_CONTROL_OFS)) begin
      // only defined bits are stored, reserved positions never hold a value
      main_nxt.regulator_enable = writedata[REGULATOR_ENABLE_POS];
      main_nxt.attach_bit       = writedata[ATTACH_BIT_POS];
      main_nxt.irq_output_mode  = usbmc_irq_mode_t'(writedata[IRQ_MODE_LSB +: 2]);
    end
    if (wr_hit(NODE_STATE_CONTROL_OFS)) begin
      node_nxt = usbmc_node_state_t'(writedata[NODE_STATE_LSB +: 2]);
    end
    if (soft_reset_bit_act) begin
      // regulator enable survives, it clears on hardware reset only
      main_nxt.attach_bit      = 1'b0;
      main_nxt.irq_output_mode = usbmc_irq_mode_t'(IRQ_MODE_RST);
      node_nxt                 = USBMC_BUS_RESET_STATE;
    end
  end

  // clock configuration ignores soft reset
  always_comb begin
    ccfg_nxt = ccfg_r;
    if (wr_hit(CLOCK_CONFIGURATION_OFS)) begin
      ccfg_nxt.clock_divisor        = writedata[CLOCK_DIVISOR_LSB +: 4];
      ccfg_nxt.clock_output_disable = writedata[CLOCK_OUT_DIS_POS];
    end
  end

  // register storage, hardware reset clears everything but the divisor, which loads CLOCK_DIVISOR_RST
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      main_r.regulator_enable <= 1'b0;
      main_r.attach_bit       <= 1'b0;
      main_r.irq_output_mode  <= USBMC_IRQ_OFF;
      ccfg_r.clock_divisor    <= CLOCK_DIVISOR_RST;
      ccfg_r.clock_output_disable <= 1'b0;
      node_r                  <= USBMC_BUS_RESET_STATE;
      soft_reset_bit_cnt_r              <= 4'h0;
    end else begin
      main_r     <= main_nxt;
      ccfg_r     <= ccfg_nxt;
      node_r     <= node_nxt;
      soft_reset_bit_cnt_r <= soft_reset_bit_cnt_nxt;
    end
  end

  // interrupt pin shaping per selected mode
  always_comb begin
    case (main_r.irq_output_mode)
      USBMC_IRQ_OFF: begin
        irq_o_nxt  = 1'b0;
        irq_oe_nxt = 1'b0;
      end
      USBMC_IRQ_LOW_OD: begin
        irq_o_nxt  = 1'b0;
        irq_oe_nxt = irq_request;  // pull low only while asserted
      end
      USBMC_IRQ_HIGH_PP: begin
        irq_o_nxt  = irq_request;
        irq_oe_nxt = 1'b1;
      end
      USBMC_IRQ_LOW_PP: begin
        irq_o_nxt  = !irq_request;
        irq_oe_nxt = 1'b1;
      end
      default: begin
        irq_o_nxt  = 1'b0;
        irq_oe_nxt = 1'b0;
      end
    endcase
  end

  // node controls decoded from state and main control
  always_comb begin
    ctl_nxt               = '0;
    ctl_nxt.regulator_on  = main_r.regulator_enable;
    ctl_nxt.force_se0     = !main_r.attach_bit;
    ctl_nxt.resume_k      = (node_r == USBMC_RESUME_STATE);
    ctl_nxt.ep_disable    = (node_r == USBMC_BUS_RESET_STATE);
    ctl_nxt.xcvr_suspend  = (node_r == USBMC_SUSPEND_STATE);
    ctl_nxt.ep_ctrl_reset = (node_r == USBMC_SUSPEND_STATE);
    ctl_nxt.state_freeze  = (node_r == USBMC_SUSPEND_STATE);
  end

  // resume event on a rising edge of bus activity while suspended
  always_comb begin
    rsm_nxt = act_s2_r && !act_s3_r && (node_r == USBMC_SUSPEND_STATE);
  end

  // output and synchroniser registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_o_r  <= 1'b0;
      irq_oe_r <= 1'b0;
      ctl_r    <= '0;
      act_s1_r <= 1'b0;
      act_s2_r <= 1'b0;
      act_s3_r <= 1'b0;
      rsm_r    <= 1'b0;
    end else begin
      irq_o_r  <= irq_o_nxt;
      irq_oe_r <= irq_oe_nxt;
      ctl_r    <= ctl_nxt;
      act_s1_r <= bus_activity;
      act_s2_r <= act_s1_r;
      act_s3_r <= act_s2_r;
      rsm_r    <= rsm_nxt;
    end
  end

  assign irq_pin_o      = irq_o_r;
  assign irq_pin_oe     = irq_oe_r;
  assign node_ctl       = ctl_r;
  assign resume_detect  = rsm_r;
  assign soft_reset_out = soft_reset_bit_act;

  // divided clock output, reset by hardware reset only
  usbmc_clock_output_pin u_clock_output_pin (
    .clock   (clock),
    .rst     (rst),
    .divisor (ccfg_r.clock_divisor),
    .freeze  (ccfg_r.clock_output_disable),
    .clk_out (clock_output_pin)
  );

endmodule

// ==== core/usbmc_pkg.sv ====
// package: offsets, field layouts, reset values and timing for the usb node main control registers
package usbmc_pkg;

  // register byte offsets on the avalon slave, one aligned word each
  localparam logic [3:0] MAIN_CONTROL_OFS        = 4'h0;
  localparam logic [3:0] CLOCK_CONFIGURATION_OFS = 4'h4;
  localparam logic [3:0] CHIP_REVISION_OFS       = 4'h8;
  localparam logic [3:0] NODE_STATE_CONTROL_OFS  = 4'hc;

  // main_control field positions
  localparam int SOFT_RESET_BIT_POS   = 0;
  localparam int REGULATOR_ENABLE_POS = 2;
  localparam int ATTACH_BIT_POS       = 3;
  localparam int IRQ_MODE_LSB         = 6;

  // clock_configuration field positions
  localparam int CLOCK_DIVISOR_LSB  = 0;
  localparam int CLOCK_OUT_DIS_POS  = 7;

  // node_state_control field position
  localparam int NODE_STATE_LSB = 0;

  // values after reset
  localparam logic [3:0] CLOCK_DIVISOR_RST = 4'hb;
  localparam logic [1:0] IRQ_MODE_RST      = 2'h0;

  // clock rate and length of the internal soft reset sequence
  localparam int         CLK_HZ            = 50000000;
  localparam logic [3:0] SOFT_RESET_CYCLES = 4'h8;

  // interrupt pin behaviour
  typedef enum logic [1:0] {
    USBMC_IRQ_OFF,
    USBMC_IRQ_LOW_OD,
    USBMC_IRQ_HIGH_PP,
    USBMC_IRQ_LOW_PP
  } usbmc_irq_mode_t;

  // node functional state, declaration order equals the field encoding
  typedef enum logic [1:0] {
    USBMC_BUS_RESET_STATE,
    USBMC_RESUME_STATE,
    USBMC_OPERATIONAL_STATE,
    USBMC_SUSPEND_STATE
  } usbmc_node_state_t;

  // main control fields held by the block
  typedef struct packed {
    usbmc_irq_mode_t irq_output_mode;
    logic            attach_bit;
    logic            regulator_enable;
  } usbmc_main_t;

  // clock configuration fields
  typedef struct packed {
    logic       clock_output_disable;
    logic [3:0] clock_divisor;
  } usbmc_clkcfg_t;

  // controls handed to the transceiver and the endpoint logic
  typedef struct packed {
    logic regulator_on;
    logic force_se0;
    logic resume_k;
    logic xcvr_suspend;
    logic ep_disable;
    logic ep_ctrl_reset;
    logic state_freeze;
  } usbmc_node_ctl_t;

endpackage

// ==== core/usbmc_clock_output_pin.sv ====
// module: glitch-free divided clock output with freeze control
`timescale 1ns/1ps
module usbmc_clock_output_pin
  import usbmc_pkg::*;
(
  input  wire logic       clock,     // system clock
  input  wire logic       rst,       // hardware reset only, async high
  input  wire logic [3:0] divisor,   // period is divisor plus one cycles, two cycles for divisor zero
  input  wire logic       freeze,    // hold output level
  output logic            clk_out    // divided clock output
);

  logic       out_r;       // present output level
  logic       out_nxt;
  logic [3:0] cnt_r;       // cycles spent in current phase
  logic [3:0] cnt_nxt;
  logic       frz_r;       // freeze seen last cycle
  logic       frz_nxt;
  logic [4:0] per;         // full period in cycles
  logic [3:0] hi_len;      // high phase length
  logic [3:0] lo_len;      // low phase length
  logic [3:0] cur_len;     // length of the running phase

  // phase lengths follow the live divisor, so a change stretches or shortens the phase under way
  always_comb begin
    per     = {1'b0, divisor} + 5'h01;
    hi_len  = per[4:1] + {3'h0, per[0]};
    lo_len  = (per[4:1] == 4'h0) ? 4'h1 : per[4:1];  // divisor zero cannot halve, runs at half rate
    cur_len = out_r ? hi_len : lo_len;
    out_nxt = out_r;
    cnt_nxt = cnt_r;
    frz_nxt = freeze;
    if (freeze) begin
      out_nxt = out_r;
      cnt_nxt = cnt_r;
    end else if (frz_r) begin
      out_nxt = 1'b1;  // fresh period starts with a high phase
      cnt_nxt = 4'h0;
    end else if (cnt_r + 4'h1 >= cur_len) begin
      out_nxt = ~out_r;  // toggle only at a phase end, no runt pulse
      cnt_nxt = 4'h0;
    end else begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  // state registers
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_r <= 1'b1;
      cnt_r <= 4'h0;
      frz_r <= 1'b0;
    end else begin
      out_r <= out_nxt;
      cnt_r <= cnt_nxt;
      frz_r <= frz_nxt;
    end
  end

  assign clk_out = out_r;

endmodule

// ==== testbench/usbmc_regs_chk.sv ====
// checker: timing relations on the node control register ports
`timescale 1ns/1ps
module usbmc_regs_chk
  import usbmc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h5  // as the bound design
)
(
  input wire logic            clock,          // system clock
  input wire logic            rst,            // hardware reset
  input wire logic [3:0]      address,        // bus address
  input wire logic            read,           // bus read
  input wire logic            waitrequest,    // bus stall
  input wire logic [31:0]     readdata,       // bus read data
  input wire logic            bus_activity,   // usb activity
  input wire logic            resume_detect,  // resume pulse
  input wire logic            soft_reset_out, // soft reset level
  input wire usbmc_node_ctl_t node_ctl        // node controls
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // soft reset runs for the fixed sequence length, then drops
  soft_reset_bit_len_a: assert property ($rose(soft_reset_out) |-> soft_reset_out[*8] ##1 !soft_reset_out)
    else $error("soft reset length wrong");
  // soft reset must pull the bus to se0 and disable the pipes
  soft_reset_bit_se0_a: assert property ($rose(soft_reset_out) |-> ##[1:3] (node_ctl.force_se0 && node_ctl.ep_disable))
    else $error("soft reset left node attached");
  // regulator survives a soft reset
  reg_keep_a: assert property (soft_reset_out && $past(node_ctl.regulator_on) |-> node_ctl.regulator_on)
    else $error("regulator dropped by soft reset");
  // only one node state drives its controls at a time
  state_excl_a: assert property ($onehot0({node_ctl.resume_k, node_ctl.xcvr_suspend, node_ctl.ep_disable}))
    else $error("node state controls overlap");
  // suspend also resets endpoints and freezes state
  susp_ctl_a: assert property (node_ctl.xcvr_suspend |-> node_ctl.ep_ctrl_reset && node_ctl.state_freeze)
    else $error("suspend controls incomplete");
  // resume event only while suspended, one cycle wide
  res_only_a: assert property (resume_detect |-> node_ctl.xcvr_suspend ##1 !resume_detect)
    else $error("resume event outside suspend");
  // activity while suspended is reported within a few cycles
  res_bound_a: assert property ($rose(bus_activity) && node_ctl.xcvr_suspend |-> ##[1:6] resume_detect)
    else $error("resume event missing");
  // revision field answers every revision read
  rev_read_a: assert property (read && !waitrequest && address == CHIP_REVISION_OFS
    |-> readdata[3:0] == REVISION)
    else $error("revision field wrong");
  // main scenarios reached
  soft_reset_bit_c: cover property ($rose(soft_reset_out));
  res_c: cover property (resume_detect);
  resk_c: cover property (node_ctl.resume_k);
endmodule

// ==== testbench/usbmc_hub_model.sv ====
// partner: upstream hub port that sees attach and makes bus traffic
`timescale 1ns/1ps
module usbmc_hub_model
  import usbmc_pkg::*;
(
  input  wire logic            clock,        // system clock
  input  wire usbmc_node_ctl_t node_ctl,     // controls from the node
  input  wire logic            activity_req, // bench asks for traffic
  output logic                 bus_activity, // usb non-idle level
  output logic                 attach_seen   // hub detects the node
);
  logic act_r = 1'b0;                        // registered traffic level
  // attach visible only with regulator up and se0 released
  assign attach_seen  = node_ctl.regulator_on & ~node_ctl.force_se0;
  assign bus_activity = act_r;
  // forced se0 masks all traffic, so no event can come from a hidden node
  always @(posedge clock) begin
    act_r <= activity_req & ~node_ctl.force_se0;
  end
endmodule

// ==== testbench/usbmc_regs_tb_top.sv ====
// testbench: avalon stimulus and port checks for the node control registers
`timescale 1ns/1ps
module usbmc_regs_tb_top;
  import usbmc_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m;} usbmc_exp_t; // expected read and mask
  localparam logic [3:0] REVISION = 4'h9;    // arbitrary revision value
  logic            clock = 1'b0;             // 50 mhz clock
  logic            rst, read, write;         // reset and bus strobes
  logic [3:0]      address, byteenable;      // bus address, enables
  logic [31:0]     writedata, readdata;      // bus data
  logic            waitrequest, irq_request; // stall, device interrupt
  logic            irq_pin_o, irq_pin_oe;    // interrupt pin
  logic            clock_output_pin;         // divided clock
  logic            bus_activity, resume_detect, soft_reset_out, activity_req, attach_seen;
  usbmc_node_ctl_t node_ctl;                 // node controls
  int              n_fail = 0;               // mismatches
  int              tests_run = 0;            // comparisons
  logic [31:0]     seed = 32'hde1d3a1d;      // xorshift state
  usbmc_exp_t      q[$];                     // pending read notes
  usbmc_exp_t      e;                        // note under compare
  logic [3:0]      dl [4] = '{4'h0, 4'h4, 4'hb, 4'hf};     // divisors tried
  logic [6:0]      ns [4] = '{7'h44, 7'h50, 7'h40, 7'h4b}; // controls per state

  always #10 clock = ~clock;

  usbmc_regs #(.REVISION(REVISION)) uut (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq_request(irq_request), .irq_pin_o(irq_pin_o), .irq_pin_oe(irq_pin_oe),
    .clock_output_pin(clock_output_pin), .bus_activity(bus_activity), .resume_detect(resume_detect),
    .soft_reset_out(soft_reset_out), .node_ctl(node_ctl));
  usbmc_hub_model hub (.clock(clock), .node_ctl(node_ctl), .activity_req(activity_req),
    .bus_activity(bus_activity), .attach_seen(attach_seen));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one avalon transfer: held until waitrequest is seen low at an edge
  task automatic bus(input logic [3:0] a, input logic is_rd, input logic [7:0] d, input logic [3:0] be);
    int k;
    logic w;
    logic [31:0] r;
    r = xs();
    @(posedge clock);
    address <= a;
    read <= is_rd;
    write <= ~is_rd;
    writedata <= {r[31:8], d};
    byteenable <= be;
    for (k = 0; k < 20; k++) begin
      @(negedge clock);
      w = waitrequest;
      @(posedge clock);
      if (w === 1'b0) break;
    end
    read <= 1'b0;
    write <= 1'b0;
    if (k == 20) begin
      n_fail++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(a, 1'b0, d, 4'h1);
  endtask
  // reserved bits read zero but go unchecked, the mask hides them
  task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
    q.push_back('{d, m});
    bus(a, 1'b1, 8'h00, 4'hf);
  endtask
  // traffic burst from the hub, counting resume events
  task automatic act(input int n);
    int c;
    @(posedge clock);
    activity_req <= 1'b1;
    c = 0;
    repeat (12) begin
      @(negedge clock);
      if (resume_detect === 1'b1) c++;
    end
    @(posedge clock);
    activity_req <= 1'b0;
    chk(32'(c), 32'(n));
  endtask
  // measure one high and one low phase after a divisor change
  task automatic clk_per(input logic [3:0] d);
    int h, l, k, dv;
    dv = int'(d);
    wr(CLOCK_CONFIGURATION_OFS, {4'h0, d});
    cyc(40);
    for (k = 0; k < 40 && clock_output_pin !== 1'b0; k++) @(negedge clock);
    for (k = 0; k < 40 && clock_output_pin !== 1'b1; k++) @(negedge clock);
    for (h = 0; h < 40 && clock_output_pin === 1'b1; h++) @(negedge clock);
    for (l = 0; l < 40 && clock_output_pin === 1'b0; l++) @(negedge clock);
    chk(32'(h), 32'((dv + 2) / 2));
    chk(32'(l), 32'(dv == 0 ? 1 : (dv + 1) / 2));
  endtask

  // each finished read is matched to the oldest note
  always @(negedge clock) begin
    if (read === 1'b1 && waitrequest === 1'b0) begin
      e = q.pop_front();
      chk(readdata & e.m, e.d & e.m);
    end
  end

  initial begin
    int i, j, k, c;
    logic [7:0] v;
    logic b;
    {rst, read, write, address, writedata, byteenable, irq_request, activity_req} = {3'b100, 42'h0};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cyc(2);
    chk({25'h0, node_ctl}, 32'h24);
    rd(MAIN_CONTROL_OFS, 32'h0, 32'hcd);
    rd(CLOCK_CONFIGURATION_OFS, 32'h0b, 32'h8f);
    rd(CHIP_REVISION_OFS, {28'h0, REVISION}, 32'hf);
    rd(NODE_STATE_CONTROL_OFS, 32'h0, 32'h3);
    rd(4'h2, 32'h0, 32'hff);
    $display("test reset values done");
    // random regulator and interrupt mode, other low-byte bits written as zero; refused writes leave no trace
    v = 8'(xs()) & 8'hc4;
    wr(MAIN_CONTROL_OFS, v);
    rd(MAIN_CONTROL_OFS, {24'h0, v}, 32'hcd);
    bus(CLOCK_CONFIGURATION_OFS, 1'b0, 8'h83, 4'h0);
    wr(CHIP_REVISION_OFS, 8'h0f);
    wr(4'h2, 8'hff);
    rd(CLOCK_CONFIGURATION_OFS, 32'h0b, 32'h8f);
    rd(CHIP_REVISION_OFS, {28'h0, REVISION}, 32'hf);
    v = 8'(xs()) & 8'h03;
    wr(NODE_STATE_CONTROL_OFS, v);
    rd(NODE_STATE_CONTROL_OFS, {24'h0, v}, 32'h3);
    $display("test register access done");
    // regulator first, attach one ms later; resume held the same ms
    wr(MAIN_CONTROL_OFS, 8'h04);
    wr(NODE_STATE_CONTROL_OFS, 8'h01);
    cyc(50000);
    wr(MAIN_CONTROL_OFS, 8'h0c);
    // bus reset state first, held 100 us
    wr(NODE_STATE_CONTROL_OFS, 8'h00);
    cyc(5000);
    wr(NODE_STATE_CONTROL_OFS, 8'h02);
    cyc(3);
    chk({31'h0, attach_seen}, 32'h1);
    for (i = 0; i < 4; i++) begin
      wr(NODE_STATE_CONTROL_OFS, 8'(i));
      cyc(3);
      chk({25'h0, node_ctl}, {25'h0, ns[i]});
    end
    $display("test node states done");
    wr(NODE_STATE_CONTROL_OFS, 8'h03);
    act(1);
    wr(NODE_STATE_CONTROL_OFS, 8'h02);
    act(0);
    $display("test resume event done");
    for (i = 0; i < 4; i++) begin
      wr(MAIN_CONTROL_OFS, {2'(i), 6'h0c});
      for (j = 0; j < 2; j++) begin
        b = j[0];
        @(posedge clock);
        irq_request <= b;
        cyc(3);
        chk({30'h0, irq_pin_o, irq_pin_oe}, {30'h0, i == 0 ? 2'b00 : i == 1 ? {1'b0, b} :
          i == 2 ? {b, 1'b1} : {~b, 1'b1}});
      end
    end
    $display("test interrupt pin done");
    for (i = 0; i < 4; i++) clk_per(dl[i]);
    wr(CLOCK_CONFIGURATION_OFS, 8'h8b);
    cyc(2);
    b = clock_output_pin;
    c = 0;
    repeat (30) begin
      @(negedge clock);
      if (clock_output_pin !== b) c++;
    end
    chk(32'(c), 32'h0);
    wr(CLOCK_CONFIGURATION_OFS, 8'h0b);
    cyc(2);
    chk({31'h0, clock_output_pin}, 32'h1);
    $display("test clock output done");
    // soft reset keeps clock setup and regulator, clears the rest
    wr(CLOCK_CONFIGURATION_OFS, 8'h05);
    wr(NODE_STATE_CONTROL_OFS, 8'h02);
    wr(MAIN_CONTROL_OFS, 8'hcd);
    rd(MAIN_CONTROL_OFS, 32'h01, 32'h01);
    for (k = 0; k < 30 && soft_reset_out !== 1'b0; k++) cyc(1);
    // a sequence that never ends uses up the bound and counts here
    chk({31'h0, soft_reset_out}, 32'h0);
    cyc(2);
    rd(MAIN_CONTROL_OFS, 32'h04, 32'hcd);
    rd(CLOCK_CONFIGURATION_OFS, 32'h05, 32'h8f);
    rd(NODE_STATE_CONTROL_OFS, 32'h0, 32'h3);
    $display("test soft reset done");
    // a hardware reset mid-run clears regulator and sets the divisor back to 4'hb
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    cyc(2);
    rd(MAIN_CONTROL_OFS, 32'h0, 32'hcd);
    rd(CLOCK_CONFIGURATION_OFS, 32'h0b, 32'h8f);
    cyc(2);
    $display("test hardware reset done");
    finish_test();
  end
endmodule

bind usbmc_regs usbmc_regs_chk #(.REVISION(REVISION)) chk_i (.clock(clock), .rst(rst), .address(address),
  .read(read), .waitrequest(waitrequest), .readdata(readdata), .bus_activity(bus_activity),
  .resume_detect(resume_detect), .soft_reset_out(soft_reset_out), .node_ctl(node_ctl));
